/* File: rtl/tws_receiver.sv */
// Purpose: Tuning word receiver for the tunable capacitor.
// Assumes: Link wires are asynchronous and sampled by clk_sys.
//   Serial clock high and low phases last two clocks or more.
// Notes: The busy output models settling and wake-up times.
//   A new word during wake-up does not cut the wake-up short.
//
// What this block does
// - Master raises enable before any clock pulse.
// - Capture one bit per rising serial clock.
// - Word travels most significant bit first.
// - Master changes data after falling clock edges.
// - Enable falling edge loads and applies word.
// - No bit count; last eight bits kept.
// - Master sends zeros in bits seven, six.
// - Bit five one selects low-current standby.
// - Bits four to zero select state.
// - Shared clock and data, separate enables.
// - Respond only while own enable is high.
// - Shared enable requires loading every device.
// - Enable stays low at least gap time.
// - Capacitance settles within twelve microseconds.
// - Standby exit recovers within seventy microseconds.
`include "tws_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module tws_receiver
	import tws_pkg::*;
#(
	parameter int SETTLE_CYC = `TWS_SETTLE_CYC,
	parameter int WAKE_CYC   = `TWS_WAKE_CYC
) (
	// System.
	input  wire logic       clk_sys,
	input  wire logic       srst,
	// Link.
	tws_if.receiver         link,
	// Tuning state.
	output logic            tunable_capacitor_standby,
	output logic [4:0]      tunable_capacitor_state,
	output logic [7:0]      tuning_control_word,
	output logic            tunable_capacitor_busy
);
	if (SETTLE_CYC < 1 || SETTLE_CYC > 65535) begin : g_bad_settle
		$error("SETTLE_CYC must lie between 1 and 65535.");
	end
	if (WAKE_CYC < 1 || WAKE_CYC > 65535) begin : g_bad_wake
		$error("WAKE_CYC must lie between 1 and 65535.");
	end

	localparam tws_word_t CTRL_RESET = `TWS_CTRL_RESET;

	logic [2:0]  sync_en;
	logic [2:0]  next_sync_en;
	logic [2:0]  sync_clk;
	logic [2:0]  next_sync_clk;
	logic [1:0]  sync_dat;
	logic [1:0]  next_sync_dat;
	logic [7:0]  shift;
	wire  [7:0]  next_shift;
	logic        sclk_rise;
	logic        sen_fall;
	logic        capture;
	logic [7:0]  next_ctrl;
	tws_word_t   new_word;
	tws_word_t   cur_word;
	logic        word_changed;
	logic        waking;
	logic        next_standby;
	logic [4:0]  next_state_code;
	logic [15:0] settle_cnt;
	logic [15:0] next_settle_cnt;
	logic [15:0] wake_cnt;
	logic [15:0] next_wake_cnt;

	// Enable synchroniser; only the second and third stages are read.
	always_comb begin
		next_sync_en = {sync_en[1:0], link.serial_latch_enable};
	end

	always_ff @(posedge clk_sys) begin
		if (srst)
			sync_en <= 3'h0;
		else
			sync_en <= next_sync_en;
	end

	// Serial clock synchroniser.
	always_comb begin
		next_sync_clk = {sync_clk[1:0], link.serial_clock};
	end

	always_ff @(posedge clk_sys) begin
		if (srst)
			sync_clk <= 3'h0;
		else
			sync_clk <= next_sync_clk;
	end

	// Data synchroniser; two stages line it up with the clock edge.
	always_comb begin
		next_sync_dat = {sync_dat[0], link.serial_data};
	end

	always_ff @(posedge clk_sys) begin
		if (srst)
			sync_dat <= 2'h0;
		else
			sync_dat <= next_sync_dat;
	end

	// Edges come from the second and third stages only.
	assign sclk_rise = sync_clk[1] && !sync_clk[2];
	assign sen_fall  = !sync_en[1] && sync_en[2];
	assign capture   = sclk_rise && sync_en[1];

	// Bit 0 takes the data and each higher stage its neighbour on a capture; no bit count is kept.
	for (genvar i = 0; i < `TWS_WORD_W; i++) begin : g_shift
		if (i == 0) begin : g_first
			assign next_shift[i] = capture ? sync_dat[1] : shift[i];
		end else begin : g_rest
			assign next_shift[i] = capture ? shift[i-1] : shift[i];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst)
			shift <= `TWS_CTRL_RESET;
		else
			shift <= next_shift;
	end

	assign new_word     = tws_word_t'(shift);
	assign cur_word     = tws_word_t'(tuning_control_word);
	assign word_changed = (shift != tuning_control_word);
	assign waking       = cur_word.standby_select && !new_word.standby_select;

	// The whole word is applied at the enable's falling edge.
	always_comb begin
		next_ctrl = tuning_control_word;
		if (sen_fall)
			next_ctrl = shift;
	end

	always_ff @(posedge clk_sys) begin
		if (srst)
			tuning_control_word <= `TWS_CTRL_RESET;
		else
			tuning_control_word <= next_ctrl;
	end

	// Outputs are loaded at the same edge as the control register.
	always_comb begin
		next_standby    = tunable_capacitor_standby;
		next_state_code = tunable_capacitor_state;
		if (sen_fall) begin
			next_standby    = new_word.standby_select;
			next_state_code = new_word.state_code;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			tunable_capacitor_standby <= CTRL_RESET.standby_select;
			tunable_capacitor_state   <= CTRL_RESET.state_code;
		end else begin
			tunable_capacitor_standby <= next_standby;
			tunable_capacitor_state   <= next_state_code;
		end
	end

	// State changes count down the settling time.
	always_comb begin
		next_settle_cnt = settle_cnt;
		if (settle_cnt != 16'h0000)
			next_settle_cnt = settle_cnt - 16'h0001;
		if (sen_fall && !waking && word_changed)
			next_settle_cnt = 16'(SETTLE_CYC);
	end

	always_ff @(posedge clk_sys) begin
		if (srst)
			settle_cnt <= 16'h0000;
		else
			settle_cnt <= next_settle_cnt;
	end

	// Leaving standby counts down the longer wake-up time.
	always_comb begin
		next_wake_cnt = wake_cnt;
		if (wake_cnt != 16'h0000)
			next_wake_cnt = wake_cnt - 16'h0001;
		if (sen_fall && waking)
			next_wake_cnt = 16'(WAKE_CYC);
	end

	always_ff @(posedge clk_sys) begin
		if (srst)
			wake_cnt <= 16'h0000;
		else
			wake_cnt <= next_wake_cnt;
	end

	assign tunable_capacitor_busy = (settle_cnt != 16'h0000) ||
		(wake_cnt != 16'h0000);
endmodule
`default_nettype wire

/* File: pkg/tws_regs.svh */
// Purpose: Constants for the tuning word serial link.
// Assumes: 25 MHz system clock on both ends.
// Notes: Times are in nanoseconds; counts derive from them.
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH
`define TWS_WORD_W          8
`define TWS_RSVD_HI_POS     7
`define TWS_RSVD_LO_POS     6
`define TWS_STANDBY_POS     5
`define TWS_STATE_MSB       4
`define TWS_STATE_LSB       0
`define TWS_CTRL_RESET      8'h00
`define TWS_CLK_NS          40
`define TWS_GAP_NS          38.4
`define TWS_GAP_CYC         int'($ceil(`TWS_GAP_NS / `TWS_CLK_NS))
`define TWS_SETTLE_NS       12000
`define TWS_SETTLE_CYC      (`TWS_SETTLE_NS / `TWS_CLK_NS)
`define TWS_WAKE_NS         70000
`define TWS_WAKE_CYC        (`TWS_WAKE_NS / `TWS_CLK_NS)
`define TWS_HALF_DIV        4
`endif

/* File: pkg/tws_pkg.sv */
// Purpose: Types shared by both ends of the tuning word link.
// Assumes: Nothing beyond the constants header.
// Notes: The word layout mirrors the control register.
package tws_pkg;
	typedef struct packed {
		logic [1:0] reserved;
		logic       standby_select;
		logic [4:0] state_code;
	} tws_word_t;
	typedef enum logic [2:0] {
		TWS_IDLE, TWS_OPEN, TWS_LOW, TWS_HIGH, TWS_CLOSE, TWS_GAP
	} tws_mst_t;
endpackage

/* File: pkg/tws_if.sv */
// Purpose: Three-wire link between master and receiver.
// Assumes: The master drives every wire.
// Notes: No clocking block; both ends sample on their own clock.
`timescale 1ns/1ns
`default_nettype none
interface tws_if;
	logic serial_latch_enable;
	logic serial_clock;
	logic serial_data;
	modport master (output serial_latch_enable, output serial_clock,
		output serial_data);
	modport receiver (input serial_latch_enable, input serial_clock,
		input serial_data);
endinterface
`default_nettype wire

/* File: rtl/tws_master.sv */
// Purpose: Serial master that sends one tuning word per request.
// Assumes: Receiver samples the link with its own clock.
// Notes: Serial clock is clk_sys divided; one request at a time.
`include "tws_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module tws_master
	import tws_pkg::*;
#(
	parameter int HALF_DIV = `TWS_HALF_DIV
) (
	// System.
	input  wire logic       clk_sys,
	input  wire logic       srst,
	// Request.
	input  wire logic       send_valid,
	input  wire logic       send_standby,
	input  wire logic [4:0] send_state,
	output logic            send_ready,
	output logic            send_done,
	// Link.
	tws_if.master           link
);
	if (HALF_DIV < 2 || HALF_DIV > 255) begin : g_bad_div
		$error("HALF_DIV must lie between 2 and 255.");
	end

	localparam int GAP = (`TWS_GAP_CYC < HALF_DIV) ? HALF_DIV : `TWS_GAP_CYC;

	tws_mst_t   state;
	tws_mst_t   next_state;
	logic [7:0] cnt;
	logic [7:0] next_cnt;
	logic [2:0] bitn;
	logic [2:0] next_bitn;
	logic [7:0] word;
	logic [7:0] next_word;
	logic       en;
	logic       next_en;
	logic       sck;
	logic       next_sck;
	logic       done;
	logic       next_done;
	logic       tick;

	assign tick       = (cnt == 8'h00);
	assign send_ready = (state == TWS_IDLE);

	always_comb begin
		next_state = state;
		next_cnt   = tick ? 8'h00 : cnt - 8'h01;
		next_bitn  = bitn;
		next_word  = word;
		next_en    = en;
		next_sck   = sck;
		next_done  = 1'b0;
		case (state)
			TWS_IDLE: begin
				if (send_valid) begin
					next_word  = {2'b00, send_standby, send_state};
					next_en    = 1'b1;
					next_cnt   = 8'(HALF_DIV - 1);
					next_bitn  = 3'h7;
					next_state = TWS_OPEN;
				end
			end
			TWS_OPEN, TWS_LOW: begin
				if (tick) begin
					next_sck   = 1'b1;
					next_cnt   = 8'(HALF_DIV - 1);
					next_state = TWS_HIGH;
				end
			end
			TWS_HIGH: begin
				if (tick) begin
					next_sck  = 1'b0;
					next_word = {word[6:0], 1'b0};
					next_cnt  = 8'(HALF_DIV - 1);
					next_bitn = bitn - 3'h1;
					next_state = (bitn == 3'h0) ? TWS_CLOSE : TWS_LOW;
				end
			end
			TWS_CLOSE: begin
				if (tick) begin
					next_en    = 1'b0;
					next_done  = 1'b1;
					next_cnt   = 8'(GAP - 1);
					next_state = TWS_GAP;
				end
			end
			TWS_GAP: begin
				if (tick)
					next_state = TWS_IDLE;
			end
			default: next_state = TWS_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state <= TWS_IDLE;
			cnt   <= 8'h00;
			bitn  <= 3'h0;
			word  <= 8'h00;
			en    <= 1'b0;
			sck   <= 1'b0;
			done  <= 1'b0;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
			bitn  <= next_bitn;
			word  <= next_word;
			en    <= next_en;
			sck   <= next_sck;
			done  <= next_done;
		end
	end

	assign link.serial_latch_enable = en;
	assign link.serial_clock        = sck;
	assign link.serial_data         = word[7];
	assign send_done                = done;
endmodule
`default_nettype wire

/* File: sim/tws_link_assertions.sv */
// Purpose: Watches the wires between master and receiver.
// Assumes: Master half period of four clocks.
// Notes: One clock domain.
`timescale 1ns/1ns
`default_nettype none
module tws_link_assertions (
	// System.
	input wire logic clk_sys,
	input wire logic srst,
	// Link.
	input wire logic serial_latch_enable,
	input wire logic serial_clock,
	input wire logic serial_data
);
	logic       sc_q;
	logic [3:0] rises;
	logic [3:0] next_rises;
	always_comb begin
		next_rises = serial_latch_enable ? rises : 4'h0;
		if (serial_latch_enable && serial_clock && !sc_q)
			next_rises = rises + 4'h1;
	end
	always_ff @(posedge clk_sys) begin
		sc_q  <= srst ? 1'b0 : serial_clock;
		rises <= srst ? 4'h0 : next_rises;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	sequence s_high;
		serial_clock [*4] ##1 !serial_clock;
	endsequence
	a_clk_in_frame: assert property (
		$rose(serial_clock) |-> serial_latch_enable)
		else $error("clock outside frame");
	a_open_first: assert property (
		$rose(serial_latch_enable) |-> !serial_clock)
		else $error("clock high at open");
	a_rsvd_first: assert property (
		$rose(serial_latch_enable) |-> !serial_data)
		else $error("first bit not zero");
	a_data_hold: assert property (
		serial_clock |-> $stable(serial_data))
		else $error("data moved while high");
	a_high_span: assert property (
		$rose(serial_clock) |-> s_high)
		else $error("high phase length");
	a_low_span: assert property (
		$fell(serial_clock) |-> !serial_clock [*4])
		else $error("low phase length");
	a_word_len: assert property (
		$fell(serial_latch_enable) |-> rises == 4'h8)
		else $error("frame not eight bits");
	a_gap_low: assert property (
		$fell(serial_latch_enable) |-> !serial_latch_enable [*4])
		else $error("enable gap short");
endmodule
`default_nettype wire

/* File: sim/tws_receiver_bench.sv */
// Purpose: Bench for the tuning word link.
// Assumes: Short busy counts of 5 and 9.
// Notes: A second receiver is driven by hand.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
	err_total++; $display("mismatch %s exp %h got %h", n, e, g); end end
module tws_receiver_bench;
	logic       clk_sys = 1'b0;
	logic       srst = 1'b1;
	logic       send_valid = 1'b0;
	logic       send_standby = 1'b0;
	logic [4:0] send_state = 5'h00;
	logic       send_ready, send_done, stby, busy;
	logic [4:0] state;
	logic [7:0] word, word2;
	logic [5:0] words [7] = '{6'h00, 6'h1F, 6'h0A, 6'h15, 6'h01, 6'h21, 6'h01};
	int         err_total = 0;
	int         tests_run = 0;
	tws_if      l1 ();
	tws_if      l2 ();
	tws_master i_tws_master (.clk_sys(clk_sys), .srst(srst),
		.send_valid(send_valid), .send_standby(send_standby),
		.send_state(send_state), .send_ready(send_ready),
		.send_done(send_done), .link(l1.master));
	tws_receiver #(.SETTLE_CYC(5), .WAKE_CYC(9)) i_tws_receiver (
		.clk_sys(clk_sys), .srst(srst), .link(l1.receiver),
		.tunable_capacitor_standby(stby), .tunable_capacitor_state(state),
		.tuning_control_word(word), .tunable_capacitor_busy(busy));
	tws_receiver #(.SETTLE_CYC(5), .WAKE_CYC(9)) i_tws_receiver_b (
		.clk_sys(clk_sys), .srst(srst), .link(l2.receiver),
		.tunable_capacitor_standby(), .tunable_capacitor_state(),
		.tuning_control_word(word2), .tunable_capacitor_busy());
	tws_link_assertions i_tws_link_assertions (.clk_sys(clk_sys),
		.srst(srst), .serial_latch_enable(l1.serial_latch_enable),
		.serial_clock(l1.serial_clock), .serial_data(l1.serial_data));
	initial forever #20 clk_sys = ~clk_sys;
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic send(input logic [5:0] v, input logic eb, input logic ew);
		int n;
		n = 0;
		send_valid   <= 1'b1;
		send_standby <= v[5];
		send_state   <= v[4:0];
		do @(posedge clk_sys); while (send_ready !== 1'b1);
		send_valid <= 1'b0;
		while (send_done !== 1'b1 && n < 200) begin
			@(posedge clk_sys);
			n++;
		end
		`CHK("done", 1'b1, send_done)
		repeat (5) @(posedge clk_sys);
		`CHK("word", {2'b00, v}, word)
		`CHK("state", v[4:0], state)
		`CHK("standby", v[5], stby)
		`CHK("busy", eb, busy)
		repeat (4) @(posedge clk_sys);
		`CHK("wake busy", ew, busy)
		repeat (8) @(posedge clk_sys);
		`CHK("idle", 1'b0, busy)
	endtask
	task automatic raw(input logic [11:0] w, input int n, input logic en);
		l2.serial_latch_enable <= en;
		for (int i = n - 1; i >= 0; i--) begin
			l2.serial_data <= w[i];
			repeat (4) @(posedge clk_sys);
			l2.serial_clock <= 1'b1;
			repeat (4) @(posedge clk_sys);
			l2.serial_clock <= 1'b0;
		end
		repeat (4) @(posedge clk_sys);
		l2.serial_latch_enable <= 1'b0;
		l2.serial_data <= ~w[0];
		repeat (8) @(posedge clk_sys);
	endtask
	initial begin
		l2.serial_latch_enable = 1'b0;
		l2.serial_clock = 1'b0;
		l2.serial_data = 1'b0;
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		`CHK("reset word", 8'h00, word)
		`CHK("reset busy", 1'b0, busy)
		$display("test reset done");
		for (int i = 0; i < 7; i++) send(words[i], i != 0, i == 6);
		$display("test master done");
		raw(12'hF15, 12, 1'b1);
		`CHK("last eight", 8'h15, word2)
		raw(12'h0EA, 8, 1'b0);
		`CHK("deselected", 8'h15, word2)
		raw(12'h000, 0, 1'b1);
		`CHK("no stray bits", 8'h15, word2)
		$display("test raw link done");
		close_out();
	end
	initial begin
		repeat (5000) @(posedge clk_sys);
		err_total++;
		close_out();
	end
endmodule
`default_nettype wire
